/* hdl/pfta_flash_ctrl.v */
`default_nettype none
`include "pfta_defs.vh"

// Contract
// - unlock port stores nothing and always reads zero
// - word select programs two bytes, else a 64-byte block
// - erase select makes next write start erase instead
// - writes allowed only with write permit, which resets clear
// - error flag sets on write start, clears on normal completion
// - software sets write start only; hardware clears it when done
// - 8-bit data latch holds byte of each table transfer
// - pointer is three bytes forming 22 bits; top bit config space
// - pointer auto step changes only low 21 bits
// - table read uses all 22 bits and loads data latch
// - table write stores latch into holding register at bits 5:0
// - timed write targets 64-byte block from bits 21:6, or in word mode the word from bits 21:1
// - erase clears block of top 12 bits, lower bits ignored
// - four pointer actions: none, post inc, post dec, pre inc
// - upper byte bit 5 is pointer bit 21, bits 4:0 are 20:16
// - control bits 5..1 as placed; bits 7, 6, 0 read zero
// - error flag stays 1 after interrupted or improper write; a reset longer than one cycle clears it
module pfta_flash_ctrl (
  input  wire        mclk,
  input  wire        sys_rst,
  input  wire [2:0]  sfr_sel,
  input  wire        sfr_wr,
  input  wire        sfr_rd,
  input  wire [7:0]  sfr_wdata,
  output reg  [7:0]  sfr_rdata,
  input  wire        tbl_rd_req,
  input  wire        tbl_wr_req,
  input  wire [1:0]  tbl_ptr_act,
  output wire        tbl_busy,
  output wire        flash_busy,
  output reg  [21:0] fl_addr,
  output reg         fl_rd,
  input  wire [7:0]  fl_rdata,
  output reg         fl_wr,
  output reg  [7:0]  fl_wdata,
  output reg         fl_erase,
  input  wire        fl_ready
);

  localparam ST_IDLE  = 3'h0;
  localparam ST_RDWT  = 3'h1;
  localparam ST_PRE   = 3'h2;
  localparam ST_PROG  = 3'h3;
  localparam ST_ERASE = 3'h4;
  localparam ST_DONE  = 3'h5;

  reg [2:0]  state_ff;
  reg [21:0] ptr_ff;
  reg [7:0]  latch_ff;
  reg        word_prog_ff;
  reg        erase_sel_ff;
  reg        wr_err_ff;
  reg        wr_permit_ff;
  reg        wr_start_ff;
  reg [1:0]  unlock_ff;
  reg [10:0] cnt_ff;
  reg [10:0] len_ff;
  reg [1:0]  rd_act_ff;
  reg        hold_pend_ff;

  wire [7:0] hold_q;
  wire       hold_we;
  wire [5:0] hold_ridx;
  wire       ctl_wr;
  wire       start_ok;
  wire       bad_start;
  wire       tbl_idle;
  wire [20:0] ptr_inc;
  wire [20:0] ptr_dec;

  assign tbl_idle   = (state_ff == ST_IDLE);
  assign tbl_busy   = !tbl_idle;
  assign flash_busy = wr_start_ff;
  assign ctl_wr     = sfr_wr && (sfr_sel == `PFTA_SEL_CONTROL);
  assign ptr_inc    = ptr_ff[20:0] + 21'h00_0001;
  assign ptr_dec    = ptr_ff[20:0] - 21'h00_0001;
  // start only right after 55h, AAh and with permit already set
  assign start_ok = ctl_wr && sfr_wdata[`PFTA_BIT_WR_START] &&
                    wr_permit_ff && (unlock_ff == 2'h2) &&
                    !wr_start_ff && tbl_idle;
  assign bad_start = ctl_wr && sfr_wdata[`PFTA_BIT_WR_START] &&
                     !start_ok && !wr_start_ff && !sys_rst;
  assign hold_we  = tbl_wr_req && tbl_idle && !wr_start_ff;
  assign hold_ridx = cnt_ff[5:0];

  pfta_hold_mem pfta_hold_mem_i (
    .mclk    (mclk),
    .wr_en   (hold_we),
    .wr_idx  (((tbl_ptr_act == `PFTA_PA_PRE_INC) ? ptr_inc[5:0]
               : ptr_ff[5:0])),
    .wr_data (latch_ff),
    .rd_idx  (hold_ridx),
    .rd_data (hold_q)
  );

  // unlock sequence tracker, any other register write breaks it
  always @(posedge mclk) begin
    if (sys_rst) begin
      unlock_ff <= 2'h0;
    end else if (sfr_wr) begin
      if (sfr_sel == `PFTA_SEL_UNLOCK &&
          sfr_wdata == `PFTA_UNLOCK_KEY1) begin
        unlock_ff <= 2'h1;
      end else if (sfr_sel == `PFTA_SEL_UNLOCK &&
                   sfr_wdata == `PFTA_UNLOCK_KEY2 &&
                   unlock_ff == 2'h1) begin
        unlock_ff <= 2'h2;
      end else begin
        unlock_ff <= 2'h0;
      end
    end
  end

  // control register
  always @(posedge mclk) begin
    if (sys_rst) begin
      word_prog_ff <= 1'b0;
      erase_sel_ff <= 1'b0;
      wr_permit_ff <= 1'b0;
      wr_start_ff  <= 1'b0;
    end else begin
      if (ctl_wr) begin
        word_prog_ff <= sfr_wdata[`PFTA_BIT_WORD_PROG];
        erase_sel_ff <= sfr_wdata[`PFTA_BIT_ERASE];
        wr_permit_ff <= sfr_wdata[`PFTA_BIT_WR_PERMIT];
      end
      if (start_ok) begin
        wr_start_ff <= 1'b1;
      end else if (state_ff == ST_DONE) begin
        wr_start_ff <= 1'b0;
      end
    end
  end

  // error flag: survives a one-cycle reset of a write cut short
  always @(posedge mclk) begin
    if (start_ok || bad_start) begin
      wr_err_ff <= 1'b1;
    end else if (state_ff == ST_DONE) begin
      wr_err_ff <= 1'b0;
    end else if (sys_rst && !wr_start_ff) begin
      wr_err_ff <= 1'b0;
    end
  end

  // pointer, latch and sequencer
  always @(posedge mclk) begin
    if (sys_rst) begin
      state_ff     <= ST_IDLE;
      ptr_ff       <= `PFTA_RST_PTR;
      latch_ff     <= `PFTA_RST_BYTE;
      cnt_ff       <= 11'h000;
      len_ff       <= 11'h000;
      rd_act_ff    <= `PFTA_PA_NONE;
      hold_pend_ff <= 1'b0;
      fl_addr      <= `PFTA_RST_PTR;
      fl_rd        <= 1'b0;
      fl_wr        <= 1'b0;
      fl_wdata     <= `PFTA_RST_BYTE;
      fl_erase     <= 1'b0;
    end else begin
      fl_rd    <= 1'b0;
      fl_wr    <= 1'b0;
      fl_erase <= 1'b0;
      hold_pend_ff <= 1'b0;
      case (state_ff)
        ST_IDLE: begin
          if (sfr_wr) begin
            case (sfr_sel)
              `PFTA_SEL_PTR_UPPER: begin
                ptr_ff[21:16] <= sfr_wdata[5:0];
              end
              `PFTA_SEL_PTR_HIGH: begin
                ptr_ff[15:8] <= sfr_wdata;
              end
              `PFTA_SEL_PTR_LOW: begin
                ptr_ff[7:0] <= sfr_wdata;
              end
              `PFTA_SEL_DATA_LATCH: begin
                latch_ff <= sfr_wdata;
              end
              default: begin
              end
            endcase
          end
          if (start_ok) begin
            cnt_ff <= 11'h000;
            fl_addr <= {ptr_ff[`PFTA_BLOCK_MSB:`PFTA_BLOCK_LSB],
                        10'h000};
            if (sfr_wdata[`PFTA_BIT_ERASE]) begin
              state_ff <= ST_ERASE;
              fl_erase <= 1'b1;
            end else begin
              // word mode keeps the word inside the holding index
              len_ff <= sfr_wdata[`PFTA_BIT_WORD_PROG] ?
                        `PFTA_WORD_BYTES : 11'h040;
              if (sfr_wdata[`PFTA_BIT_WORD_PROG]) begin
                cnt_ff  <= {5'h00, ptr_ff[5:1], 1'b0};
                fl_addr <= {ptr_ff[21:1], 1'b0};
              end else begin
                fl_addr <= {ptr_ff[21:6], 6'h00};
              end
              state_ff <= ST_PRE;
            end
          end else if (tbl_rd_req) begin
            if (tbl_ptr_act == `PFTA_PA_PRE_INC) begin
              fl_addr <= {ptr_ff[21], ptr_inc};
              ptr_ff[20:0] <= ptr_inc;
            end else begin
              fl_addr <= ptr_ff;
            end
            fl_rd     <= 1'b1;
            rd_act_ff <= tbl_ptr_act;
            state_ff  <= ST_RDWT;
          end else if (hold_we) begin
            case (tbl_ptr_act)
              `PFTA_PA_POST_INC: ptr_ff[20:0] <= ptr_inc;
              `PFTA_PA_POST_DEC: ptr_ff[20:0] <= ptr_dec;
              `PFTA_PA_PRE_INC:  ptr_ff[20:0] <= ptr_inc;
              default: begin
              end
            endcase
          end
        end
        ST_RDWT: begin
          if (fl_ready) begin
            latch_ff <= fl_rdata;
            case (rd_act_ff)
              `PFTA_PA_POST_INC: ptr_ff[20:0] <= ptr_inc;
              `PFTA_PA_POST_DEC: ptr_ff[20:0] <= ptr_dec;
              default: begin
              end
            endcase
            state_ff <= ST_IDLE;
          end
        end
        ST_PRE: begin
          // holding read data registered; issue byte
          if (!hold_pend_ff && !fl_wr) begin
            hold_pend_ff <= 1'b1;
          end
          if (hold_pend_ff) begin
            fl_wdata <= hold_q;
            fl_wr    <= 1'b1;
            state_ff <= ST_PROG;
          end
        end
        ST_PROG: begin
          if (fl_ready && !fl_wr) begin
            if (len_ff == `PFTA_WORD_BYTES ? cnt_ff[0] :
                cnt_ff[5:0] == 6'h3F) begin
              state_ff <= ST_DONE;
            end else begin
              cnt_ff  <= cnt_ff + 11'h001;
              fl_addr <= fl_addr + 22'h00_0001;
              state_ff <= ST_PRE;
            end
          end
        end
        ST_ERASE: begin
          if (fl_ready && !fl_erase) begin
            state_ff <= ST_DONE;
          end
        end
        ST_DONE: begin
          state_ff <= ST_IDLE;
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // register read mux
  always @(posedge mclk) begin
    if (sys_rst) begin
      sfr_rdata <= `PFTA_RST_BYTE;
    end else if (sfr_rd) begin
      case (sfr_sel)
        `PFTA_SEL_PTR_UPPER:  sfr_rdata <= {2'b00, ptr_ff[21:16]};
        `PFTA_SEL_PTR_HIGH:   sfr_rdata <= ptr_ff[15:8];
        `PFTA_SEL_PTR_LOW:    sfr_rdata <= ptr_ff[7:0];
        `PFTA_SEL_DATA_LATCH: sfr_rdata <= latch_ff;
        `PFTA_SEL_UNLOCK:     sfr_rdata <= 8'h00;
        `PFTA_SEL_CONTROL:    sfr_rdata <= {2'b00, word_prog_ff,
                                 erase_sel_ff, wr_err_ff, wr_permit_ff,
                                 wr_start_ff, 1'b0};
        default:              sfr_rdata <= 8'h00;
      endcase
    end
  end

endmodule
`default_nettype wire

/* hdl/pfta_defs.vh */
`ifndef PFTA_DEFS_VH
`define PFTA_DEFS_VH

// register select codes on the special-function register port
`define PFTA_SEL_PTR_UPPER   3'h0
`define PFTA_SEL_PTR_HIGH    3'h1
`define PFTA_SEL_PTR_LOW     3'h2
`define PFTA_SEL_DATA_LATCH  3'h3
`define PFTA_SEL_UNLOCK      3'h4
`define PFTA_SEL_CONTROL     3'h5

// flash control field positions
`define PFTA_BIT_WORD_PROG   5
`define PFTA_BIT_ERASE       4
`define PFTA_BIT_WR_ERR      3
`define PFTA_BIT_WR_PERMIT   2
`define PFTA_BIT_WR_START    1

// pointer layout
`define PFTA_PTR_W           22
`define PFTA_PTR_LOW_W       21
`define PFTA_HOLD_IDX_W      7
`define PFTA_HOLD_DEPTH      64
`define PFTA_BLOCK_MSB       21
`define PFTA_BLOCK_LSB       10
`define PFTA_BLOCK_BYTES     11'h0400
`define PFTA_WORD_BYTES      11'h0002

// unlock sequence values
`define PFTA_UNLOCK_KEY1     8'h55
`define PFTA_UNLOCK_KEY2     8'hAA

// pointer actions
`define PFTA_PA_NONE         2'h0
`define PFTA_PA_POST_INC     2'h1
`define PFTA_PA_POST_DEC     2'h2
`define PFTA_PA_PRE_INC      2'h3

// reset values
`define PFTA_RST_BYTE        8'h00
`define PFTA_RST_PTR         22'h00_0000

// one byte cell per flash cycle by default
`define PFTA_CELL_CYCLES     4'h1

`endif

/* hdl/pfta_hold_mem.v */
`default_nettype none
`include "pfta_defs.vh"

// write holding registers, registered read
module pfta_hold_mem (
  input  wire       mclk,
  input  wire       wr_en,
  input  wire [5:0] wr_idx,
  input  wire [7:0] wr_data,
  input  wire [5:0] rd_idx,
  output reg  [7:0] rd_data
);

  reg [7:0] mem [0:`PFTA_HOLD_DEPTH-1];

  always @(posedge mclk) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_data;
    end
    rd_data <= mem[rd_idx];
  end

endmodule
`default_nettype wire

/* test/pfta_flash_ctrl_chk.sv */
`default_nettype none
module pfta_chk (
  input wire logic        mclk,
  input wire logic        sys_rst,
  input wire logic [2:0]  sfr_sel,
  input wire logic        sfr_wr,
  input wire logic        sfr_rd,
  input wire logic [7:0]  sfr_wdata,
  input wire logic [7:0]  sfr_rdata,
  input wire logic        tbl_rd_req,
  input wire logic        tbl_busy,
  input wire logic        flash_busy,
  input wire logic [21:0] fl_addr,
  input wire logic        fl_rd,
  input wire logic        fl_wr,
  input wire logic        fl_erase,
  input wire logic        fl_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  logic [6:0] wr_cnt_ff;
  logic [1:0] mode_ff;
  // byte writes of the current timed write
  always_ff @(posedge mclk) begin
    if (sys_rst || !flash_busy) wr_cnt_ff <= 7'h00;
    else if (fl_wr) wr_cnt_ff <= wr_cnt_ff + 7'h01;
    if (sfr_wr && sfr_sel == 3'h5) mode_ff <= sfr_wdata[5:4];
  end
  a_unlock_reads_zero: assert property (
    sfr_rd && sfr_sel == 3'h4 |=> sfr_rdata == 8'h00)
    else $error("unlock port read not zero");
  a_ctrl_unused_zero: assert property (
    sfr_rd && sfr_sel == 3'h5 |=> sfr_rdata[7:6] == 2'h0 && !sfr_rdata[0])
    else $error("unused control bits not zero");
  a_busy_shows_err: assert property (
    sfr_rd && sfr_sel == 3'h5 && flash_busy |=> sfr_rdata[3] && sfr_rdata[1])
    else $error("busy without start and error bits");
  a_start_needs_cmd: assert property (
    $rose(flash_busy) |-> $past(sfr_wr && sfr_sel == 3'h5 && sfr_wdata[1]))
    else $error("write started without control write");
  a_erase_block_base: assert property (
    fl_erase |-> fl_addr[9:0] == 10'h000)
    else $error("erase address not block aligned");
  a_done_after_ready: assert property (
    $fell(flash_busy) && !$past(sys_rst) |-> $past(fl_ready) || $past(fl_ready, 2))
    else $error("start cleared without flash ready");
  a_byte_count: assert property (
    $fell(flash_busy) && !$past(sys_rst) |->
      wr_cnt_ff == (mode_ff[0] ? 7'h00 : mode_ff[1] ? 7'h02 : 7'h40))
    else $error("wrong number of byte writes");
  a_read_issues: assert property (
    tbl_rd_req && !tbl_busy |=> fl_rd)
    else $error("table read not issued");
  c_start: cover property ($rose(flash_busy));
  c_erase: cover property (fl_erase);
  c_read: cover property (tbl_rd_req && !tbl_busy);
endmodule
bind pfta_flash_ctrl pfta_chk pfta_chk_i (.mclk, .sys_rst, .sfr_sel, .sfr_wr,
  .sfr_rd, .sfr_wdata, .sfr_rdata, .tbl_rd_req, .tbl_busy, .flash_busy,
  .fl_addr, .fl_rd, .fl_wr, .fl_erase, .fl_ready);
`default_nettype wire

/* test/pfta_flash_model.sv */
`default_nettype none
module pfta_flash_model (
  input  wire logic        mclk,
  input  wire logic        slow,
  input  wire logic [21:0] fl_addr,
  input  wire logic        fl_rd,
  input  wire logic        fl_wr,
  input  wire logic [7:0]  fl_wdata,
  input  wire logic        fl_erase,
  output var  logic        fl_ready,
  output var  logic [7:0]  fl_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0]  mem [int];
  logic [21:0] adr;
  int          cnt = 0;
  initial fl_ready = 1'b0;
  initial fl_rdata = 8'h00;
  // idle data toggles; one ready pulse per request
  always @(posedge mclk) begin
    fl_ready <= 1'b0;
    fl_rdata <= ~fl_rdata;
    if (fl_rd || fl_wr || fl_erase) begin
      adr = fl_addr;
      cnt = slow ? 6 : 1;
      if (fl_wr) mem[fl_addr] = fl_wdata;
      if (fl_erase)
        for (int a = 0; a < 1024; a++) mem[{fl_addr[21:10], a[9:0]}] = 8'hff;
    end else if (cnt > 0) begin
      cnt = cnt - 1;
      if (cnt == 0) begin
        fl_ready <= 1'b1;
        fl_rdata <= mem.exists(adr) ? mem[adr] : adr[7:0] ^ {adr[21], adr[14:8]};
      end
    end
  end
endmodule
`default_nettype wire

/* test/test_program_flash_table_access.sv */
`default_nettype none
`include "pfta_defs.vh"
module test_program_flash_table_access;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk, sys_rst, sfr_wr, sfr_rd, tbl_rd_req, tbl_wr_req, slow;
  logic [2:0]  sfr_sel;
  logic [7:0]  sfr_wdata, sfr_rdata, fl_rdata, fl_wdata;
  logic [1:0]  tbl_ptr_act;
  logic [21:0] fl_addr;
  logic        tbl_busy, flash_busy, fl_rd, fl_wr, fl_erase, fl_ready;
  int          fails, check_count;
  pfta_flash_ctrl pfta_flash_ctrl_i (.mclk, .sys_rst, .sfr_sel, .sfr_wr,
    .sfr_rd, .sfr_wdata, .sfr_rdata, .tbl_rd_req, .tbl_wr_req, .tbl_ptr_act,
    .tbl_busy, .flash_busy, .fl_addr, .fl_rd, .fl_rdata, .fl_wr, .fl_wdata,
    .fl_erase, .fl_ready);
  pfta_flash_model pfta_flash_model_i (.mclk, .slow, .fl_addr, .fl_rd, .fl_wr,
    .fl_wdata, .fl_erase, .fl_ready, .fl_rdata);
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  function automatic logic [7:0] fx(input logic [21:0] a);
    return a[7:0] ^ {a[21], a[14:8]};
  endfunction
  task automatic cmp(input logic [21:0] got, input logic [21:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] s, input logic [7:0] d);
    @(negedge mclk);
    sfr_sel = s;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge mclk);
    sfr_wr = 1'b0;
  endtask
  task automatic rd(input logic [2:0] s, input logic [7:0] e);
    @(negedge mclk);
    sfr_sel = s;
    sfr_rd = 1'b1;
    @(negedge mclk);
    sfr_rd = 1'b0;
    cmp(sfr_rdata, e);
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    while ((tbl_busy !== 1'b0 || flash_busy !== 1'b0) && n < 3000) begin
      @(negedge mclk);
      n++;
    end
    if (n == 3000) fails++;
  endtask
  task automatic tbl(input logic rdq, input logic [1:0] act);
    @(negedge mclk);
    tbl_ptr_act = act;
    tbl_rd_req = rdq;
    tbl_wr_req = !rdq;
    @(negedge mclk);
    tbl_rd_req = 1'b0;
    tbl_wr_req = 1'b0;
    wait_idle;
  endtask
  task automatic setp(input logic [21:0] p);
    wr(`PFTA_SEL_PTR_UPPER, {2'h3, p[21:16]});
    wr(`PFTA_SEL_PTR_HIGH, p[15:8]);
    wr(`PFTA_SEL_PTR_LOW, p[7:0]);
  endtask
  task automatic chkp(input logic [21:0] p);
    rd(`PFTA_SEL_PTR_UPPER, {2'h0, p[21:16]});
    rd(`PFTA_SEL_PTR_HIGH, p[15:8]);
    rd(`PFTA_SEL_PTR_LOW, p[7:0]);
  endtask
  task automatic go(input logic [7:0] c);
    wr(`PFTA_SEL_UNLOCK, `PFTA_UNLOCK_KEY1);
    wr(`PFTA_SEL_UNLOCK, `PFTA_UNLOCK_KEY2);
    wr(`PFTA_SEL_CONTROL, c);
  endtask
  task automatic t_reset;
    rd(`PFTA_SEL_CONTROL, 8'h00);
    rd(`PFTA_SEL_UNLOCK, 8'h00);
    chkp(22'h00_0000);
  endtask
  task automatic t_ptr;
    setp(22'h3f_ffff);
    tbl(1'b1, `PFTA_PA_POST_INC);
    rd(`PFTA_SEL_DATA_LATCH, fx(22'h3f_ffff));
    chkp(22'h20_0000);
    tbl(1'b1, `PFTA_PA_PRE_INC);
    rd(`PFTA_SEL_DATA_LATCH, fx(22'h20_0001));
    tbl(1'b1, `PFTA_PA_NONE);
    chkp(22'h20_0001);
    tbl(1'b1, `PFTA_PA_POST_DEC);
    tbl(1'b1, `PFTA_PA_POST_DEC);
    rd(`PFTA_SEL_DATA_LATCH, fx(22'h20_0000));
    chkp(22'h3f_ffff);
  endtask
  task automatic t_word;
    slow = 1'b1;
    setp(22'h00_0404);
    wr(`PFTA_SEL_DATA_LATCH, 8'ha5);
    tbl(1'b0, `PFTA_PA_POST_INC);
    wr(`PFTA_SEL_DATA_LATCH, 8'h5a);
    tbl(1'b0, `PFTA_PA_NONE);
    wr(`PFTA_SEL_CONTROL, 8'h20);
    go(8'h22);
    cmp(flash_busy, 1'b0);
    wr(`PFTA_SEL_CONTROL, 8'h24);
    wr(`PFTA_SEL_CONTROL, 8'h26);
    cmp(flash_busy, 1'b0);
    rd(`PFTA_SEL_CONTROL, 8'h2c);
    go(8'h26);
    rd(`PFTA_SEL_CONTROL, 8'h2e);
    wr(`PFTA_SEL_CONTROL, 8'h24);
    cmp(flash_busy, 1'b1);
    cmp(tbl_busy, 1'b1);
    wait_idle;
    rd(`PFTA_SEL_CONTROL, 8'h24);
    tbl(1'b1, `PFTA_PA_POST_DEC);
    rd(`PFTA_SEL_DATA_LATCH, 8'h5a);
    tbl(1'b1, `PFTA_PA_NONE);
    rd(`PFTA_SEL_DATA_LATCH, 8'ha5);
  endtask
  task automatic t_erase;
    setp(22'h00_07ff);
    wr(`PFTA_SEL_CONTROL, 8'h14);
    go(8'h16);
    wait_idle;
    rd(`PFTA_SEL_CONTROL, 8'h14);
    setp(22'h00_0405);
    tbl(1'b1, `PFTA_PA_NONE);
    rd(`PFTA_SEL_DATA_LATCH, 8'hff);
  endtask
  task automatic t_block;
    slow = 1'b0;
    setp(22'h00_0c00);
    wr(`PFTA_SEL_CONTROL, 8'h04);
    go(8'h06);
    wait_idle;
    rd(`PFTA_SEL_CONTROL, 8'h04);
    setp(22'h00_0c05);
    tbl(1'b1, `PFTA_PA_NONE);
    rd(`PFTA_SEL_DATA_LATCH, 8'h5a);
    go(8'h06);
    repeat (10) @(negedge mclk);
    sys_rst = 1'b1;
    @(negedge mclk);
    sys_rst = 1'b0;
    rd(`PFTA_SEL_CONTROL, 8'h08);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    {sfr_wr, sfr_rd, tbl_rd_req, tbl_wr_req, slow} = 5'h00;
    sfr_sel = 3'h0;
    sfr_wdata = 8'h00;
    tbl_ptr_act = 2'h0;
    sys_rst = 1'b1;
    repeat (5) @(negedge mclk);
    sys_rst = 1'b0;
    t_reset;
    t_ptr;
    t_word;
    t_erase;
    t_block;
    finish_test;
  end
  initial begin
    #(50 * 20000);
    fails++;
    finish_test;
  end
endmodule
`default_nettype wire
